// *** inc/msp_params.svh ***
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH
// Register byte offsets.
`define MSP_OFS_CTRL 12'h000
`define MSP_OFS_STATUS 12'h004
`define MSP_OFS_TXCNT 12'h008
`define MSP_OFS_NKEY 12'h010
`define MSP_OFS_LKEY 12'h020
// Control fields.
`define MSP_CTRL_EE 0
`define MSP_CTRL_EO 1
`define MSP_CTRL_COORD 2
`define MSP_CTRL_APPLY 3
`define MSP_CTRL_RST 32'h0000_0000
// Counter limits and overhead, in bytes.
`define MSP_CNT_MAX 32'hFFFF_FFFF
`define MSP_NWK_OVH 8'd18
`define MSP_APS_OVH 8'd9
`define MSP_MAX_RF 8'd84
`define MSP_LFSR_SEED 32'h1234_5678
`endif

// *** inc/msp_pkg.sv ***
`default_nettype none
package msp_pkg;
  typedef enum logic [1:0] {MSP_DATA, MSP_ROUTE, MSP_CMD, MSP_BEACON} msp_kind_t;
  typedef struct packed {
    logic [15:0] dest;
    logic bcast;
    logic aps;
    msp_kind_t kind;
    logic [7:0] len;
    logic [31:0] data;
  } msp_txreq_t;
  typedef struct packed {
    logic secured;
    logic [31:0] counter;
    logic [63:0] src;
    logic aps;
    msp_kind_t kind;
    logic [7:0] len;
    logic [31:0] data;
    logic [31:0] aps_mic;
    logic [31:0] nwk_mic;
  } msp_frame_t;
endpackage : msp_pkg
`default_nettype wire

// *** verilog/msp_core.sv ***
`include "msp_params.svh"
`default_nettype none
module msp_core #(
  parameter int NEIGH = 8, // Neighbour table depth.
  parameter int NW = $clog2(NEIGH),
  parameter logic [63:0] OWN_ADDR = 64'h0000_0000_0000_0001 // Arbitrary value.
) (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic tx_valid, // Host transmit request.
  output logic tx_ready, // Request accepted.
  input wire msp_pkg::msp_txreq_t tx_req, // Request contents.
  output logic txf_valid, // Frame to radio.
  output msp_pkg::msp_frame_t txf, // Outgoing frame.
  output logic tx_refused, // Request rejected pulse.
  input wire logic rx_valid, // Frame from radio.
  input wire msp_pkg::msp_frame_t rxf, // Received frame.
  input wire logic [NW-1:0] rx_neigh, // Sender table slot.
  input wire logic rx_for_me, // This node is destination.
  output logic rx_out_valid, // Delivered payload pulse.
  output logic [31:0] rx_out_data, // Delivered payload.
  output logic rx_drop, // Dropped frame pulse.
  input wire logic key_update, // Over-air network key replacement.
  input wire logic [127:0] key_update_val, // New network key.
  input wire logic join_req, // Joining node asks for key.
  output logic key_out_valid, // Key delivery pulse.
  output logic key_out_clear, // Delivered unencrypted.
  output logic [127:0] key_out, // Delivered key.
  output logic key_refused, // Join refused pulse.
  output logic leave_net // Leave and rejoin pulse.
);
  import msp_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] active_ctrl;
  logic [127:0] nkey_wr;
  logic [127:0] lkey_wr;
  logic [127:0] nkey_rand;
  logic [127:0] lkey_rand;
  logic [127:0] net_key;
  logic [127:0] link_key;
  logic [31:0] tx_cnt;
  logic [31:0] lfsr;
  logic [31:0] neigh_cnt [NEIGH];
  logic [7:0] drop_cnt;
  logic ee;
  logic eo;
  logic coord;
  logic saturated;
  logic apb_wr;
  logic apb_rd;
  logic nkey_wen;
  logic key_change;
  logic fwd_now;
  logic rx_nwk_ok;
  logic rx_cnt_ok;
  logic rx_aps_ok;
  logic tx_take;
  logic tx_secure;
  logic tx_aps;
  logic len_ok;
  logic [7:0] max_len;
  logic [31:0] rx_plain;
  msp_frame_t rx_inner;

  // Keyed 32-bit mix used for both the keystream and the integrity codes.
  function automatic logic [31:0] mix(input logic [127:0] k, input logic [31:0] x);
    logic [31:0] v;
    v = x ^ k[31:0];
    for (int i = 0; i < 4; i++) begin
      v = {v[26:0], v[31:27]} + k[32*i +: 32];
      v = v ^ {v[12:0], v[31:13]} ^ 32'h9E37_79B9;
    end
    return v;
  endfunction : mix

  // Network code over counter, source, APS header bits, length and data.
  function automatic logic [31:0] nwk_code(input logic [127:0] k, input msp_frame_t f);
    return mix(k, f.counter ^ f.src[31:0] ^ f.src[63:32]
      ^ {21'h0, f.aps, f.kind, f.len} ^ mix(k, f.data ^ f.aps_mic));
  endfunction : nwk_code

  // APS code covers only the APS header and payload, end to end.
  function automatic logic [31:0] aps_code(input logic [127:0] k, input msp_frame_t f);
    return mix(k, {21'h0, f.aps, f.kind, f.len} ^ mix(k, f.data));
  endfunction : aps_code

  assign ee = active_ctrl[`MSP_CTRL_EE];
  assign eo = active_ctrl[`MSP_CTRL_EO];
  assign coord = active_ctrl[`MSP_CTRL_COORD];
  assign saturated = (tx_cnt == `MSP_CNT_MAX);

  // A zero written key means the node runs on its randomly drawn one.
  assign net_key = (nkey_wr == 128'h0) ? nkey_rand : nkey_wr;
  assign link_key = (lkey_wr == 128'h0) ? lkey_rand : lkey_wr;

  // APB slave: zero wait states, unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !((paddr == `MSP_OFS_CTRL) || (paddr == `MSP_OFS_STATUS)
        || (paddr == `MSP_OFS_TXCNT) || ((paddr >> 4) == (`MSP_OFS_NKEY >> 4))
        || ((paddr >> 4) == (`MSP_OFS_LKEY >> 4)));
    end
  end

  // Only the coordinator may set its own network key.
  assign nkey_wen = apb_wr && coord && (paddr[11:4] == `MSP_OFS_NKEY >> 4);
  assign key_change = nkey_wen || key_update;

  // Read data is registered in the setup cycle; keys are write-only and read zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      unique case (paddr)
        `MSP_OFS_CTRL: prdata <= ctrl;
        `MSP_OFS_STATUS: prdata <= {16'h0, drop_cnt, 5'h0, saturated, coord, ee};
        `MSP_OFS_TXCNT: prdata <= tx_cnt;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register plus apply: settings take effect only when applied.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `MSP_CTRL_RST;
      active_ctrl <= `MSP_CTRL_RST;
      leave_net <= 1'b0;
    end else begin
      leave_net <= 1'b0;
      if (apb_wr && paddr == `MSP_OFS_CTRL) begin
        ctrl <= {28'h0, 1'b0, pwdata[2:0]};
        if (pwdata[`MSP_CTRL_APPLY]) begin
          active_ctrl <= {29'h0, pwdata[2:0]};
          leave_net <= (pwdata[`MSP_CTRL_EE] != active_ctrl[`MSP_CTRL_EE]);
        end
      end
    end
  end

  // Written keys; byte lanes are whole words since APB here has no strobes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nkey_wr <= 128'h0;
      lkey_wr <= 128'h0;
    end else begin
      if (nkey_wen) begin
        nkey_wr[32*paddr[3:2] +: 32] <= pwdata;
      end else if (key_update) begin
        nkey_wr <= key_update_val;
      end
      if (apb_wr && paddr[11:4] == `MSP_OFS_LKEY >> 4) begin
        lkey_wr[32*paddr[3:2] +: 32] <= pwdata;
      end
    end
  end

  // Free-running LFSR; random keys are drawn on each leave pulse, i.e. after an apply that changes EE.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= `MSP_LFSR_SEED;
      nkey_rand <= 128'h0;
      lkey_rand <= 128'h0;
    end else begin
      lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      if (leave_net) begin
        nkey_rand <= {lfsr, ~lfsr, mix(128'h0, lfsr), mix(nkey_rand, lfsr)};
        lkey_rand <= {mix(lkey_rand, lfsr), lfsr ^ 32'h5A5A_5A5A, ~lfsr, lfsr};
      end
    end
  end

  // Payload limits shrink by the security overheads in force.
  assign tx_secure = ee && (tx_req.kind != MSP_BEACON);
  assign tx_aps = tx_req.aps && ee && !tx_req.bcast;
  always_comb begin
    max_len = `MSP_MAX_RF;
    if (tx_secure) begin
      max_len = max_len - `MSP_NWK_OVH;
    end
    if (tx_aps) begin
      max_len = max_len - `MSP_APS_OVH;
    end
  end
  assign len_ok = (tx_req.len <= max_len);

  // Receive checks: replay, network code, and APS code when we are the end.
  assign rx_cnt_ok = (rxf.counter >= neigh_cnt[rx_neigh]);
  assign rx_nwk_ok = !rxf.secured || (nwk_code(net_key, rxf) == rxf.nwk_mic);
  assign rx_aps_ok = !rxf.aps || !rx_for_me
    || (aps_code(link_key, rx_inner) == rxf.aps_mic);
  // Network ciphering is stripped hop by hop, exposing the APS layer beneath.
  always_comb begin
    rx_inner = rxf;
    if (rxf.secured) begin
      rx_inner.data = rxf.data ^ mix(net_key, rxf.counter ^ rxf.src[31:0]);
    end
  end
  // APS ciphering is removed only at the end of the route.
  always_comb begin
    rx_plain = rx_inner.data;
    if (rxf.aps && rx_for_me) begin
      rx_plain = rx_plain ^ mix(link_key, {24'h0, rxf.len});
    end
  end

  // A frame to relay takes the transmitter this cycle, so the host waits.
  assign fwd_now = rx_valid && !rx_for_me && rx_nwk_ok && rx_cnt_ok
    && !(rxf.secured && saturated);
  assign tx_ready = !saturated && !fwd_now;
  assign tx_take = tx_valid && tx_ready && len_ok;

  // Own frame counter: one step per secured frame sent or relayed, held at the top, cleared on rekey.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt <= 32'h0000_0000;
    end else if (key_change) begin
      tx_cnt <= 32'h0000_0000;
    end else if ((tx_take && tx_secure) || (fwd_now && rxf.secured)) begin
      tx_cnt <= tx_cnt + 32'h0000_0001;
    end
  end

  // Neighbour table keeps the last counter heard from each sender.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NEIGH; i++) begin
        neigh_cnt[i] <= 32'h0000_0000;
      end
    end else if (key_change) begin
      for (int i = 0; i < NEIGH; i++) begin
        neigh_cnt[i] <= 32'h0000_0000;
      end
    end else if (rx_valid && rxf.secured && rx_nwk_ok && rx_cnt_ok) begin
      neigh_cnt[rx_neigh] <= rxf.counter;
    end
  end

  // Outgoing frame builder for both host frames and relayed frames.
  always_ff @(posedge clock or negedge rst_n) begin
    msp_frame_t f;
    if (!rst_n) begin
      txf_valid <= 1'b0;
      txf <= '0;
      tx_refused <= 1'b0;
    end else begin
      f = '0;
      txf_valid <= 1'b0;
      tx_refused <= tx_valid && !fwd_now && (saturated || !len_ok);
      if (fwd_now) begin
        // Relay keeps any APS layer untouched and re-secures with our identity.
        f = rxf;
        f.data = rx_plain;
        if (rxf.secured) begin
          f.counter = tx_cnt;
          f.src = OWN_ADDR;
          f.data = f.data ^ mix(net_key, tx_cnt ^ OWN_ADDR[31:0]);
          f.nwk_mic = nwk_code(net_key, f);
        end
        txf <= f;
        txf_valid <= 1'b1;
      end else if (tx_take) begin
        f.aps = tx_aps;
        f.kind = tx_req.kind;
        f.len = tx_req.len;
        f.data = tx_req.data;
        f.src = OWN_ADDR;
        if (tx_aps) begin
          f.data = f.data ^ mix(link_key, {24'h0, tx_req.len});
          f.aps_mic = aps_code(link_key, f);
        end
        if (tx_secure) begin
          f.secured = 1'b1;
          f.counter = tx_cnt;
          f.data = f.data ^ mix(net_key, tx_cnt ^ OWN_ADDR[31:0]);
          f.nwk_mic = nwk_code(net_key, f);
        end
        txf <= f;
        txf_valid <= 1'b1;
      end
    end
  end

  // Delivery to the host and drop accounting.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_valid <= 1'b0;
      rx_out_data <= 32'h0000_0000;
      rx_drop <= 1'b0;
      drop_cnt <= 8'h00;
    end else begin
      rx_out_valid <= 1'b0;
      rx_drop <= 1'b0;
      if (rx_valid) begin
        if (!(rx_nwk_ok && rx_cnt_ok && rx_aps_ok)) begin
          rx_drop <= 1'b1;
          drop_cnt <= drop_cnt + 8'h01;
        end else if (rx_for_me) begin
          rx_out_valid <= 1'b1;
          rx_out_data <= rx_plain;
        end
      end
    end
  end

  // Key delivery to joiners: under the preconfigured link key, else in the clear if EO is set, else refused.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_out_valid <= 1'b0;
      key_out_clear <= 1'b0;
      key_out <= 128'h0;
      key_refused <= 1'b0;
    end else begin
      key_out_valid <= 1'b0;
      key_refused <= 1'b0;
      if (join_req && ee && coord) begin
        if (lkey_wr != 128'h0) begin
          key_out_valid <= 1'b1;
          key_out_clear <= 1'b0;
          key_out <= net_key ^ {mix(link_key, 32'h0000_0000), mix(link_key, 32'h0000_0001),
            mix(link_key, 32'h0000_0002), mix(link_key, 32'h0000_0003)};
        end else if (eo) begin
          key_out_valid <= 1'b1;
          key_out_clear <= 1'b1;
          key_out <= net_key;
        end else begin
          key_refused <= 1'b1;
        end
      end else if (join_req) begin
        key_refused <= 1'b1;
      end
    end
  end
endmodule : msp_core
`default_nettype wire

// *** verification/msp_core_sva.sv ***
`include "msp_params.svh"
`default_nettype none
module msp_core_sva
  import msp_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic tx_valid, // Request.
  input wire logic tx_ready, // Accept.
  input wire msp_pkg::msp_txreq_t tx_req, // Contents.
  input wire logic txf_valid, // Frame out.
  input wire msp_pkg::msp_frame_t txf, // Frame.
  input wire logic tx_refused, // Refusal.
  input wire logic rx_valid, // Frame in.
  input wire logic rx_for_me, // Destination.
  input wire logic rx_out_valid, // Delivery.
  input wire logic rx_drop, // Drop.
  input wire logic key_update, // Key change.
  input wire logic join_req, // Join.
  input wire logic key_out_valid, // Key sent.
  input wire logic key_refused, // Join refused.
  input wire logic leave_net // Leave.
);
  // An applied control write is needed for a leave, though not every one causes it.
  logic apply_now;
  assign apply_now = psel && penable && pwrite && paddr == `MSP_OFS_CTRL
    && pwdata[`MSP_CTRL_APPLY];
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_bcast;
    tx_valid && tx_ready && tx_req.bcast ##1 txf_valid;
  endsequence
  sequence s_join_ans;
    ##1 (key_out_valid != key_refused);
  endsequence
  tx_cause_a: assert property (
    txf_valid |-> $past(tx_valid && tx_ready) || $past(rx_valid && !rx_for_me))
    else $error("frame without cause");
  cnt_step_a: assert property (
    txf_valid && $past(txf_valid) && !$past(key_update) && !$past(psel)
    |-> txf.counter == $past(txf.counter) + 32'h1) else $error("counter step");
  beacon_plain_a: assert property (
    txf_valid && txf.kind == MSP_BEACON |-> !txf.secured) else $error("beacon secured");
  bcast_aps_a: assert property (s_bcast |-> !txf.aps) else $error("aps on bcast");
  refuse_cause_a: assert property (
    tx_refused |-> $past(tx_valid) && !txf_valid) else $error("bad refusal");
  rx_answer_a: assert property (
    rx_out_valid || rx_drop |-> $past(rx_valid) && !(rx_out_valid && rx_drop))
    else $error("bad receive answer");
  hop_deliver_a: assert property (
    rx_out_valid |-> $past(rx_for_me)) else $error("delivered at hop");
  join_answer_a: assert property (
    join_req |-> s_join_ans) else $error("join answer");
  leave_cause_a: assert property (
    leave_net |-> $past(apply_now)) else $error("leave without apply");
endmodule : msp_core_sva
`default_nettype wire

// *** verification/msp_nbr_model.sv ***
`default_nettype none
module msp_nbr_model
  import msp_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic txf_valid, // Frame heard.
  input wire msp_pkg::msp_frame_t txf, // Heard frame.
  output logic rx_valid, // Frame sent.
  output var msp_pkg::msp_frame_t rxf, // Sent frame.
  output logic [2:0] rx_neigh, // Sender slot.
  output logic rx_for_me // Destination flag.
);
  msp_frame_t heard;
  // Idle outputs start quiet.
  initial begin
    rx_valid = 1'b0;
    rxf = '0;
    rx_neigh = 3'h0;
    rx_for_me = 1'b0;
  end
  // Frames the node sends are kept, as a real neighbour would hear them.
  always @(posedge clock) begin
    if (txf_valid) begin
      heard <= txf;
    end
  end
  // One frame for one cycle; afterwards the lines show garbage, not the old frame.
  task automatic send(input msp_frame_t g, input logic [2:0] s, input logic me);
    @(posedge clock);
    rx_valid <= 1'b1;
    rxf <= g;
    rx_neigh <= s;
    rx_for_me <= me;
    @(posedge clock);
    rx_valid <= 1'b0;
    rxf <= ~g;
    rx_for_me <= ~me;
  endtask : send
endmodule : msp_nbr_model
`default_nettype wire

// *** verification/test_mesh_packet_security.sv ***
`include "msp_params.svh"
`default_nettype none
module test_mesh_packet_security;
  timeunit 1ns;
  timeprecision 1ns;
  import msp_pkg::*;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rx_out_data;
  logic tx_valid, tx_ready, txf_valid, tx_refused, rx_valid, rx_for_me, fv, fr;
  logic rx_out_valid, rx_drop, key_update, join_req, key_out_valid;
  logic key_out_clear, key_refused, leave_net;
  logic [2:0] rx_neigh;
  logic [127:0] key_update_val, key_out;
  msp_txreq_t tx_req;
  msp_frame_t txf, rxf, f, f1, f2, fa;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  msp_core dut (.*);
  msp_nbr_model nbr (.*);
  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // The request is held until the edge that sees pready high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tx(input msp_kind_t k, input logic [7:0] n, input logic a, input logic b);
    @(posedge clock);
    tx_req <= '{dest: 16'h0002, bcast: b, aps: a, kind: k, len: n, data: 32'hC0DE_0000 + n};
    tx_valid <= 1'b1;
    do @(negedge clock); while (tx_ready !== 1'b1);
    @(posedge clock);
    tx_valid <= 1'b0;
    @(negedge clock);
    fv = txf_valid;
    fr = tx_refused;
    f = txf;
  endtask : tx
  task automatic rx(input msp_frame_t g, input logic [2:0] s, input logic me);
    nbr.send(g, s, me);
    @(negedge clock);
  endtask : rx
  task automatic join_pulse();
    @(posedge clock);
    join_req <= 1'b1;
    @(posedge clock);
    join_req <= 1'b0;
    @(negedge clock);
  endtask : join_pulse
  task automatic s_regs();
    apb(1'b0, `MSP_OFS_CTRL, 32'h0);
    chk("ctrl read", rd, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", err, 1'b1);
    apb(1'b0, `MSP_OFS_NKEY, 32'h0);
    chk("key read", rd, 32'h0);
    apb(1'b1, `MSP_OFS_LKEY, 32'h0000_0005);
    apb(1'b1, `MSP_OFS_CTRL, 32'h0000_000D);
    @(negedge clock);
    chk("leave", leave_net, 1'b1);
    apb(1'b0, `MSP_OFS_STATUS, 32'h0);
    chk("status", rd[2:0], 3'h3);
  endtask : s_regs
  task automatic s_tx();
    tx(MSP_DATA, 8'd4, 1'b0, 1'b0);
    f1 = f;
    chk("secured", {fv, f.secured, f.src}, {2'b11, 64'h1});
    tx(MSP_DATA, 8'd66, 1'b0, 1'b0);
    f2 = f;
    chk("count", f.counter, f1.counter + 32'h1);
    tx(MSP_BEACON, 8'd4, 1'b0, 1'b0);
    chk("beacon", {fv, f.secured}, 2'b10);
    tx(MSP_DATA, 8'd67, 1'b0, 1'b0);
    chk("too long", {fv, fr}, 2'b01);
    tx(MSP_DATA, 8'd57, 1'b1, 1'b0);
    fa = f;
    chk("aps", {fv, f.aps}, 2'b11);
    tx(MSP_DATA, 8'd58, 1'b1, 1'b0);
    chk("aps long", {fv, fr}, 2'b01);
    tx(MSP_DATA, 8'd4, 1'b1, 1'b1);
    chk("bcast", fv & f.aps, 1'b0);
  endtask : s_tx
  task automatic s_rx();
    logic [31:0] c;
    rx(f2, 3'd1, 1'b1);
    chk("deliver", {rx_out_valid, rx_out_data}, {1'b1, 32'hC0DE_0042});
    rx(f1, 3'd1, 1'b1);
    chk("replay", {rx_out_valid, rx_drop}, 2'b01);
    f = f1;
    f.nwk_mic[0] = ~f.nwk_mic[0];
    rx(f, 3'd2, 1'b1);
    chk("nwk code", rx_drop, 1'b1);
    rx(fa, 3'd3, 1'b1);
    chk("aps deliver", {rx_out_valid, rx_out_data}, {1'b1, 32'hC0DE_0039});
    f = fa;
    f.aps_mic[0] = ~f.aps_mic[0];
    rx(f, 3'd4, 1'b1);
    chk("aps code", rx_drop, 1'b1);
    tx(MSP_DATA, 8'd4, 1'b0, 1'b0);
    c = f.counter;
    rx(fa, 3'd5, 1'b0);
    chk("relay", {txf_valid, rx_out_valid, txf.aps, txf.counter}, {3'b101, c + 32'h1});
    chk("relay src", txf.src, 64'h1);
  endtask : s_rx
  task automatic s_join();
    join_pulse();
    chk("join sealed", {key_out_valid, key_out_clear}, 2'b10);
    apb(1'b1, `MSP_OFS_LKEY, 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `MSP_OFS_NKEY + 12'(4 * k), 32'h1111_0000 + k);
    end
    apb(1'b1, `MSP_OFS_CTRL, 32'h0000_000F);
    join_pulse();
    chk("join clear", {key_out_valid, key_out_clear}, 2'b11);
    chk("net key", key_out, 128'h1111_0003_1111_0002_1111_0001_1111_0000);
  endtask : s_join
  task automatic s_key();
    @(posedge clock);
    key_update <= 1'b1;
    key_update_val <= {4{32'h0BAD_F00D}};
    @(posedge clock);
    key_update <= 1'b0;
    apb(1'b0, `MSP_OFS_TXCNT, 32'h0);
    chk("count clear", rd, 32'h0);
    rx(f2, 3'd6, 1'b1);
    chk("old key", rx_drop, 1'b1);
  endtask : s_key
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Reset, then the scenarios in an order where each builds on the last.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_valid, key_update, join_req} = '0;
    tx_req = '0;
    key_update_val = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    s_regs();
    s_tx();
    s_rx();
    s_join();
    s_key();
    tally_and_finish();
  end
endmodule : test_mesh_packet_security
bind msp_core msp_core_sva chk (.*);
`default_nettype wire
